// *** inc/dmsp_pkg.sv ***
// Purpose: constants for the dual mode serial port
// Assumes: byte-wide register port, 16-bit addresses
// Notes: bit clock comes from a divider enable
package dmsp_pkg;
  localparam logic [15:0] ADDR_ASYNC_MODE = 16'hFF70;
  localparam logic [15:0] ADDR_ASYNC_STAT = 16'hFF71;
  localparam logic [15:0] ADDR_SYNC_MODE = 16'hFF72;
  localparam logic [15:0] ADDR_DATA = 16'hFF74;
  localparam logic [7:0] ASYNC_MODE_RST = 8'h00;
  localparam logic [7:0] SYNC_MODE_RST = 8'h00;
  localparam logic [7:0] TX_SHIFT_RST = 8'hFF;
  localparam int AM_TX_EN = 7;
  localparam int AM_RX_EN = 6;
  localparam int AM_PAR_HI = 5;
  localparam int AM_PAR_LO = 4;
  localparam int AM_CHAR_LEN = 3;
  localparam int AM_STOP_LEN = 2;
  localparam int SM_EN = 7;
  localparam int SM_FIRST_BIT = 2;
  localparam int SM_CLK_SEL = 1;
  localparam int ST_PARITY = 2;
  localparam int ST_FRAMING = 1;
  localparam int ST_OVERRUN = 0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam int BAUD_DIV_DEFAULT = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} dmsp_tx_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} dmsp_rx_t;
endpackage

// *** logic/dmsp_top.sv ***
// Purpose: dual mode serial port, uart or three-wire synchronous
// Assumes: pins synchronous to CLOCK; async rx sampled at bit centre
// Notes: transmit bytes queue in a fifo ahead of the shifter
`timescale 1ns/10ps

module dmsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [WIDTH-1:0] IN_DATA,
  input wire logic IN_VALID,
  output logic IN_READY,
  output logic [WIDTH-1:0] OUT_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } dmsp_fifo_t;
  dmsp_fifo_t s_reg, s_next;
  logic push, pop;
  assign IN_READY = (s_reg.wp - s_reg.rp) != (AW+1)'(DEPTH);
  assign OUT_VALID = s_reg.wp != s_reg.rp;
  assign OUT_DATA = mem[s_reg.rp[AW-1:0]];
  assign push = IN_VALID && IN_READY;
  assign pop = OUT_VALID && OUT_READY;
  always_comb begin
    s_next = s_reg;
    if (push) s_next.wp = s_reg.wp + 1'b1;
    if (pop) s_next.rp = s_reg.rp + 1'b1;
  end
  always_ff @(posedge CLOCK) begin
    if (push) mem[s_reg.wp[AW-1:0]] <= IN_DATA;
  end
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) s_reg <= '0;
    else s_reg <= s_next;
  end
endmodule // dmsp_fifo

module dmsp_top import dmsp_pkg::*; #(
  parameter int BAUD_DIV = BAUD_DIV_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [15:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  output logic TX_READY,
  input wire logic ASYNC_RX_PIN,
  output logic ASYNC_TX_PIN,
  output logic ASYNC_TX_OE_N,
  input wire logic SERIAL_IN_PIN,
  output logic SERIAL_OUT_PIN,
  output logic SERIAL_OUT_OE_N,
  input wire logic SERIAL_CLOCK_IN,
  output logic SERIAL_CLOCK_OUT,
  output logic SERIAL_CLOCK_OE_N
);
  initial begin
    if (BAUD_DIV < 2 || BAUD_DIV > 65535) $error("BAUD_DIV out of range");
  end
  typedef struct packed {
    logic [7:0] amode;
    logic [7:0] smode;
    logic [2:0] stat;
    logic [7:0] tx_shift;
    logic [7:0] rx_buf;
    logic rx_full;
    logic [15:0] div;
    logic [3:0] tx_sub;
    logic [3:0] tx_bit;
    logic tx_par;
    logic tx_line;
    dmsp_tx_t tx_st;
    logic [3:0] rx_sub;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_par;
    logic rx_prev;
    dmsp_rx_t rx_st;
    logic sy_busy;
    logic [3:0] sy_cnt;
    logic sy_clk;
    logic sclk_prev;
    logic [7:0] sy_shift;
    logic [7:0] sy_rx;
    logic sy_out;
  } dmsp_state_t;
  dmsp_state_t s_reg, s_next;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic par_bit(input logic [7:0] d, input logic len8,
                                   input logic [1:0] mode);
    logic p;
    p = ^(len8 ? d : {1'b0, d[6:0]});
    case (mode)
      PAR_ODD: par_bit = ~p;
      PAR_EVEN: par_bit = p;
      default: par_bit = 1'b0;
    endcase
  endfunction

  logic wr_data, rd_data, tick, fifo_valid, fifo_pop, sync_on, tx_on, rx_on;
  logic [7:0] fifo_data;
  logic tx_idle, sclk_fall, sclk_rise, len8;
  assign wr_data = WR && ADDR == ADDR_DATA;
  assign rd_data = RD && ADDR == ADDR_DATA;
  assign sync_on = s_reg.smode[SM_EN];
  assign tx_on = s_reg.amode[AM_TX_EN];
  assign rx_on = s_reg.amode[AM_RX_EN];
  assign len8 = s_reg.amode[AM_CHAR_LEN];
  assign tick = s_reg.div == 16'(BAUD_DIV - 1);
  assign tx_idle = s_reg.tx_st == TX_IDLE && !s_reg.sy_busy;
  // uart start waits for a tick so the start bit is a whole bit long
  assign fifo_pop = fifo_valid && tx_idle && (sync_on || (tx_on && tick));
  assign sclk_fall = s_reg.smode[SM_CLK_SEL] ? (tick && s_reg.sy_clk)
                     : (s_reg.sclk_prev && !SERIAL_CLOCK_IN);
  assign sclk_rise = s_reg.smode[SM_CLK_SEL] ? (tick && !s_reg.sy_clk)
                     : (!s_reg.sclk_prev && SERIAL_CLOCK_IN);

  dmsp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .CLOCK(CLOCK),
    .ARST_N(ARST_N),
    .IN_DATA(WDATA),
    .IN_VALID(wr_data),
    .IN_READY(TX_READY),
    .OUT_DATA(fifo_data),
    .OUT_VALID(fifo_valid),
    .OUT_READY(fifo_pop)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.sclk_prev = SERIAL_CLOCK_IN;
    s_next.rx_prev = ASYNC_RX_PIN;
    s_next.div = tick ? 16'h0000 : s_reg.div + 16'h0001;
    if (WR && ADDR == ADDR_ASYNC_MODE) s_next.amode = {WDATA[7:2], 2'b00};
    if (WR && ADDR == ADDR_SYNC_MODE) s_next.smode = {WDATA[7], 4'h0, WDATA[2:1], 1'b0};
    if (rd_data) s_next.rx_full = 1'b0;
    if (fifo_pop) begin
      s_next.tx_shift = fifo_data;
      if (sync_on) begin
        s_next.sy_busy = 1'b1;
        s_next.sy_cnt = 4'h0;
        s_next.sy_shift = fifo_data;
        s_next.sy_clk = 1'b1;
      end else begin
        s_next.tx_st = TX_START;
        s_next.tx_sub = 4'h0;
        s_next.tx_par = par_bit(fifo_data, len8, s_reg.amode[AM_PAR_HI:AM_PAR_LO]);
      end
    end
    // async transmitter, one bit per sixteen ticks
    if (tick && s_reg.tx_st != TX_IDLE) begin
      s_next.tx_sub = s_reg.tx_sub + 4'h1;
      if (s_reg.tx_sub == 4'hF) begin
        case (s_reg.tx_st)
          TX_START: begin
            s_next.tx_st = TX_DATA;
            s_next.tx_bit = 4'h0;
          end
          TX_DATA: begin
            s_next.tx_bit = s_reg.tx_bit + 4'h1;
            if (s_reg.tx_bit == (len8 ? 4'h7 : 4'h6))
              s_next.tx_st = s_reg.amode[AM_PAR_HI:AM_PAR_LO] == PAR_NONE ? TX_STOP1 : TX_PAR;
          end
          TX_PAR: s_next.tx_st = TX_STOP1;
          TX_STOP1: s_next.tx_st = s_reg.amode[AM_STOP_LEN] ? TX_STOP2 : TX_IDLE;
          default: s_next.tx_st = TX_IDLE;
        endcase
      end
    end
    if (!tx_on) s_next.tx_st = TX_IDLE;
    case (s_next.tx_st)
      TX_START: s_next.tx_line = 1'b0;
      TX_DATA: s_next.tx_line = s_reg.tx_shift[s_next.tx_bit[2:0]];
      TX_PAR: s_next.tx_line = s_reg.tx_par;
      default: s_next.tx_line = 1'b1;
    endcase
    // async receiver, start bit checked at mid bit
    if (tick) begin
      s_next.rx_sub = s_reg.rx_sub + 4'h1;
      case (s_reg.rx_st)
        RX_IDLE: begin
          s_next.rx_sub = 4'h0;
          if (!s_reg.rx_prev) s_next.rx_st = RX_START;
        end
        RX_START: begin
          if (s_reg.rx_sub == 4'h7) begin
            s_next.rx_sub = 4'h0;
            s_next.rx_bit = 4'h0;
            s_next.rx_st = s_reg.rx_prev ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (s_reg.rx_sub == 4'hF) begin
            s_next.rx_shift = {s_reg.rx_prev, s_reg.rx_shift[7:1]};
            s_next.rx_bit = s_reg.rx_bit + 4'h1;
            if (s_reg.rx_bit == (len8 ? 4'h7 : 4'h6))
              s_next.rx_st = s_reg.amode[AM_PAR_HI:AM_PAR_LO] == PAR_NONE ? RX_STOP : RX_PAR;
          end
        end
        RX_PAR: begin
          if (s_reg.rx_sub == 4'hF) begin
            s_next.rx_par = s_reg.rx_prev;
            s_next.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (s_reg.rx_sub == 4'hF) begin
            s_next.rx_st = RX_IDLE;
            s_next.rx_buf = len8 ? s_reg.rx_shift : {1'b0, s_reg.rx_shift[7:1]};
            s_next.rx_full = 1'b1;
            s_next.stat = 3'b000;
            s_next.stat[ST_FRAMING] = !s_reg.rx_prev;
            s_next.stat[ST_OVERRUN] = s_reg.rx_full && !rd_data;
            if (s_reg.amode[AM_PAR_HI])
              s_next.stat[ST_PARITY] = s_reg.rx_par != par_bit(s_next.rx_buf, len8,
                                       s_reg.amode[AM_PAR_HI:AM_PAR_LO]);
          end
        end
        default: s_next.rx_st = RX_IDLE;
      endcase
    end
    if (!rx_on) s_next.rx_st = RX_IDLE;
    // three-wire shifter: out on falling, in on rising edge
    if (s_reg.sy_busy) begin
      if (s_reg.smode[SM_CLK_SEL] && tick) s_next.sy_clk = !s_reg.sy_clk;
      if (sclk_fall)
        s_next.sy_out = s_reg.smode[SM_FIRST_BIT] ? s_reg.sy_shift[0] : s_reg.sy_shift[7];
      if (sclk_rise) begin
        s_next.sy_shift = s_reg.smode[SM_FIRST_BIT] ? {SERIAL_IN_PIN, s_reg.sy_shift[7:1]}
                          : {s_reg.sy_shift[6:0], SERIAL_IN_PIN};
        s_next.sy_cnt = s_reg.sy_cnt + 4'h1;
        if (s_reg.sy_cnt == 4'h7) begin
          s_next.sy_busy = 1'b0;
          s_next.sy_clk = 1'b1;
          s_next.rx_buf = s_next.sy_shift;
          s_next.rx_full = 1'b1;
        end
      end
    end
    if (!sync_on) begin
      s_next.sy_busy = 1'b0;
      s_next.sy_clk = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg <= '0;
      s_reg.amode <= ASYNC_MODE_RST;
      s_reg.smode <= SYNC_MODE_RST;
      s_reg.tx_shift <= TX_SHIFT_RST;
      s_reg.tx_line <= 1'b1;
      s_reg.sy_clk <= 1'b1;
      s_reg.sy_out <= 1'b1;
      s_reg.tx_st <= TX_IDLE;
      s_reg.rx_st <= RX_IDLE;
      s_reg.rx_prev <= 1'b1;
      s_reg.sclk_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // pins and readback
  // ---------------------------------------------------------------
  always_comb begin
    RDATA = 8'h00;
    case (ADDR)
      ADDR_ASYNC_MODE: RDATA = s_reg.amode;
      ADDR_ASYNC_STAT: RDATA = {5'h00, s_reg.stat};
      ADDR_SYNC_MODE: RDATA = s_reg.smode;
      ADDR_DATA: RDATA = s_reg.rx_buf;
      default: RDATA = 8'h00;
    endcase
  end
  assign ASYNC_TX_PIN = s_reg.tx_line;
  assign ASYNC_TX_OE_N = !tx_on;
  assign SERIAL_OUT_PIN = s_reg.sy_out;
  assign SERIAL_OUT_OE_N = !sync_on;
  assign SERIAL_CLOCK_OUT = s_reg.sy_clk;
  assign SERIAL_CLOCK_OE_N = !(sync_on && s_reg.smode[SM_CLK_SEL]);
endmodule // dmsp_top

// *** tb/dmsp_peer.sv ***
// Purpose: far-side uart peer and three-wire loopback device
// Assumes: one bit lasts BIT clocks
// Notes: samples cap_len bits of each tx frame at bit centres
`timescale 1ns/10ps
module dmsp_peer #(
  parameter int BIT = 32
) (
  input wire logic clock,
  input wire logic tx_line,
  output logic rx_line,
  input wire logic sout,
  input wire logic sout_oe_n,
  input wire logic sclk,
  output logic sin,
  input wire logic [3:0] cap_len,
  output logic [11:0] cap_bits,
  output logic cap_valid,
  output logic [7:0] falls
);
  logic tgl = 1'b0;
  initial rx_line = 1'b1;
  initial falls = 8'h00;
  always @(posedge clock) tgl <= ~tgl;
  always @(negedge sclk) falls <= falls + 8'h01;
  // released data line shows a changing pattern
  assign sin = sout_oe_n ? tgl : sout;
  initial begin
    cap_valid = 1'b0;
    forever begin
      @(negedge tx_line);
      cap_bits = 12'hFFF;
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < int'(cap_len); i++) begin
        cap_bits[i] = tx_line;
        if (i < int'(cap_len) - 1) repeat (BIT) @(posedge clock);
      end
      cap_valid = 1'b1;
      @(posedge clock);
      cap_valid = 1'b0;
    end
  end
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx_line <= f[i];
      repeat (BIT - 1) @(posedge clock);
    end
    @(posedge clock);
    rx_line <= 1'b1;
  endtask
endmodule // dmsp_peer

// *** tb/dmsp_top_sva.sv ***
// Purpose: port checks for the dual mode serial port
// Assumes: mode registers change only by writes
// Notes: bound into dmsp_top
`timescale 1ns/10ps
module dmsp_sva import dmsp_pkg::*; #(
  parameter int BAUD_DIV = BAUD_DIV_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [15:0] ADDR,
  input wire logic WR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic TX_READY,
  input wire logic ASYNC_TX_PIN,
  input wire logic ASYNC_TX_OE_N,
  input wire logic SERIAL_OUT_OE_N,
  input wire logic SERIAL_CLOCK_OUT,
  input wire logic SERIAL_CLOCK_OE_N
);
  localparam int BIT = 16 * BAUD_DIV;
  localparam int GO_MAX = BAUD_DIV + 1;
  logic [7:0] am_reg;
  logic [7:0] sm_reg;
  logic [15:0] lo_reg;
  logic [15:0] hi_reg;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      am_reg <= 8'h00;
      sm_reg <= 8'h00;
      lo_reg <= 16'h0000;
      hi_reg <= 16'h0000;
    end else begin
      if (WR && ADDR == ADDR_ASYNC_MODE) am_reg <= WDATA & 8'hFC;
      if (WR && ADDR == ADDR_SYNC_MODE) sm_reg <= WDATA & 8'h86;
      lo_reg <= ASYNC_TX_PIN ? 16'h0000 : lo_reg + 16'h0001;
      hi_reg <= !ASYNC_TX_PIN ? 16'h0000 : hi_reg + {15'h0000, hi_reg != 16'hFFFF};
    end
  end
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  property p_am; ADDR == ADDR_ASYNC_MODE |-> RDATA == am_reg; endproperty
  a_am: assert property (p_am) else $error("async mode readback");
  property p_sm; ADDR == ADDR_SYNC_MODE |-> RDATA == sm_reg; endproperty
  a_sm: assert property (p_sm) else $error("sync mode readback");
  property p_st; ADDR == ADDR_ASYNC_STAT |-> RDATA[7:3] == 5'h00; endproperty
  a_st: assert property (p_st) else $error("status spare bits");
  property p_toe; $stable(am_reg) [*2] |-> ASYNC_TX_OE_N == !am_reg[AM_TX_EN]; endproperty
  a_toe: assert property (p_toe) else $error("tx enable pin");
  property p_soe; $stable(sm_reg) [*2] |-> SERIAL_OUT_OE_N == !sm_reg[SM_EN]
    && SERIAL_CLOCK_OE_N == !(sm_reg[SM_EN] && sm_reg[SM_CLK_SEL]); endproperty
  a_soe: assert property (p_soe) else $error("sync enable pins");
  property p_off; !am_reg[AM_TX_EN] && ASYNC_TX_PIN |=> ASYNC_TX_PIN; endproperty
  a_off: assert property (p_off) else $error("tx while disabled");
  property p_sck; $stable(sm_reg) && !sm_reg[SM_CLK_SEL] |-> SERIAL_CLOCK_OUT; endproperty
  a_sck: assert property (p_sck) else $error("clock out active");
  property p_bit; $rose(ASYNC_TX_PIN) |-> lo_reg != 16'h0000 && lo_reg % BIT == 0; endproperty
  a_bit: assert property (p_bit) else $error("low run not whole bits");
  property p_go; WR && ADDR == ADDR_DATA && TX_READY && am_reg[AM_TX_EN]
    && hi_reg > 16'(11 * BIT) |-> ##[1:GO_MAX] !ASYNC_TX_PIN; endproperty
  a_go: assert property (p_go) else $error("no start bit");
  c_go: cover property (WR && ADDR == ADDR_DATA && am_reg[AM_TX_EN]);
  c_bit: cover property ($rose(ASYNC_TX_PIN) && lo_reg == 16'(BIT));
  c_sck: cover property (!SERIAL_CLOCK_OUT && sm_reg[SM_EN]);
endmodule // dmsp_sva
bind dmsp_top dmsp_sva #(.BAUD_DIV(BAUD_DIV)) u_sva (.CLOCK(CLOCK), .ARST_N(ARST_N),
  .ADDR(ADDR), .WR(WR), .WDATA(WDATA), .RDATA(RDATA), .TX_READY(TX_READY),
  .ASYNC_TX_PIN(ASYNC_TX_PIN), .ASYNC_TX_OE_N(ASYNC_TX_OE_N),
  .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N), .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT),
  .SERIAL_CLOCK_OE_N(SERIAL_CLOCK_OE_N));

// *** tb/dmsp_tb_top.sv ***
// Purpose: self-checking bench for the dual mode serial port
// Assumes: BAUD_DIV of 2, one bit is 32 clocks
// Notes: tx frames are checked in order through a queue
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module dmsp_tb_top import dmsp_pkg::*; ;
  localparam int BIT = 32;
  logic clock, arst_n, wr, rd, rx_pin, sin, sout, sout_oe_n, sclk, tx_pin, tx_ready, cap_valid;
  logic sck_oe_n, pclk;
  logic ext_sck = 1'b1;
  logic [7:0] s_cap;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, falls;
  logic [3:0] cap_len;
  logic [11:0] cap_bits;
  logic [11:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  dmsp_top #(.BAUD_DIV(2)) dut (.CLOCK(clock), .ARST_N(arst_n), .ADDR(addr), .WR(wr),
    .RD(rd), .WDATA(wdata), .RDATA(rdata), .TX_READY(tx_ready), .ASYNC_RX_PIN(rx_pin),
    .ASYNC_TX_PIN(tx_pin), .ASYNC_TX_OE_N(), .SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN(sout),
    .SERIAL_OUT_OE_N(sout_oe_n), .SERIAL_CLOCK_IN(ext_sck), .SERIAL_CLOCK_OUT(sclk),
    .SERIAL_CLOCK_OE_N(sck_oe_n));
  dmsp_peer #(.BIT(BIT)) peer (.clock(clock), .tx_line(tx_pin), .rx_line(rx_pin),
    .sout(sout), .sout_oe_n(sout_oe_n), .sclk(pclk), .sin(sin), .cap_len(cap_len),
    .cap_bits(cap_bits), .cap_valid(cap_valid), .falls(falls));
  // shift clock on the wire: driven by the port or by the bench
  assign pclk = sck_oe_n ? ext_sck : sclk;
  always @(posedge pclk) s_cap <= {s_cap[6:0], sout};
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] am,
                                        output int n);
    logic [11:0] f;
    logic p;
    f = {3'b111, am[AM_CHAR_LEN] ? d[7] : 1'b1, d[6:0], 1'b0};
    n = am[AM_CHAR_LEN] ? 9 : 8;
    p = ^{am[AM_CHAR_LEN] & d[7], d[6:0], am[AM_PAR_HI:AM_PAR_LO] == PAR_ODD};
    if (am[AM_PAR_HI:AM_PAR_LO] == PAR_ZERO) p = 1'b0;
    if (am[AM_PAR_HI:AM_PAR_LO] != PAR_NONE) begin
      f[n] = p;
      n++;
    end
    n = n + 1 + int'(am[AM_STOP_LEN]);
    return f;
  endfunction
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    #1;
    `CHK(rdata, e)
    @(posedge clock);
    rd <= 1'b0;
  endtask
  task automatic wait_q(input int lim);
    for (int i = 0; i < lim && exp_q.size() > 0; i++) @(posedge clock);
    `CHK(exp_q.size(), 0)
    repeat (BIT) @(posedge clock);
  endtask
  task automatic tx_case(input logic [7:0] am);
    logic [7:0] d;
    int n;
    d = 8'($urandom);
    wr_reg(ADDR_ASYNC_MODE, am);
    exp_q.push_back(frame(d, am, n));
    cap_len = 4'(n);
    wr_reg(ADDR_DATA, d);
    wait_q(1000);
  endtask
  task automatic rx_case(input logic [7:0] am, input logic [11:0] flip, input int cnt,
                         input logic [7:0] st);
    logic [7:0] d;
    logic [11:0] f;
    int n;
    d = 8'($urandom) | 8'h80;
    wr_reg(ADDR_ASYNC_MODE, am);
    f = frame(d, am, n) ^ flip;
    repeat (cnt) peer.send(f, n);
    repeat (4) @(posedge clock);
    rd_chk(ADDR_ASYNC_STAT, st);
    rd_chk(ADDR_DATA, am[AM_CHAR_LEN] ? d : {1'b0, d[6:0]});
  endtask
  task automatic sync_case(input logic [7:0] sm);
    logic [7:0] d;
    logic [7:0] f0;
    logic [7:0] r;
    d = 8'($urandom);
    for (int i = 0; i < 8; i++) r[i] = sm[SM_FIRST_BIT] ? d[7 - i] : d[i];
    wr_reg(ADDR_ASYNC_MODE, 8'h00);
    wr_reg(ADDR_SYNC_MODE, sm);
    f0 = falls;
    wr_reg(ADDR_DATA, d);
    if (!sm[SM_CLK_SEL]) begin
      repeat (8) begin
        repeat (BIT / 2) @(posedge clock);
        ext_sck <= 1'b0;
        repeat (BIT / 2) @(posedge clock);
        ext_sck <= 1'b1;
      end
    end
    for (int i = 0; i < 4000 && 8'(falls - f0) < 8'h08; i++) @(posedge clock);
    repeat (64) @(posedge clock);
    `CHK(8'(falls - f0), 8'h08)
    `CHK(s_cap, r)
    rd_chk(ADDR_DATA, d);
    wr_reg(ADDR_SYNC_MODE, 8'h00);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    logic [11:0] e;
    forever begin
      @(posedge cap_valid);
      e = exp_q.size() > 0 ? exp_q.pop_front() : 12'h000;
      `CHK(cap_bits, e)
    end
  end
  initial begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    $display("mismatch t=%0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    logic [7:0] d;
    int k;
    int n;
    {arst_n, wr, rd, addr, wdata, cap_len} = '0;
    void'($urandom(10526));
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    rd_chk(ADDR_ASYNC_MODE, ASYNC_MODE_RST);
    rd_chk(ADDR_SYNC_MODE, SYNC_MODE_RST);
    rd_chk(ADDR_ASYNC_STAT, 8'h00);
    rd_chk(16'hFF73, 8'h00);
    wr_reg(ADDR_SYNC_MODE, 8'h79);
    rd_chk(ADDR_SYNC_MODE, 8'h00);
    wr_reg(ADDR_ASYNC_MODE, 8'h03);
    rd_chk(ADDR_ASYNC_MODE, 8'h00);
    $display("test registers done");
    rx_case(8'hC8, 12'h000, 1, 8'h00);
    rx_case(8'hF0, 12'h000, 1, 8'h00);
    rx_case(8'hF0, 12'h100, 1, 8'h04);
    rx_case(8'hD8, 12'h200, 1, 8'h00);
    rx_case(8'hE8, 12'h400, 1, 8'h02);
    rx_case(8'hC8, 12'h000, 2, 8'h01);
    $display("test receive done");
    for (int i = 0; i < 4; i++) tx_case({2'b10, 2'(i), i[0], i[1], 2'b00});
    wr_reg(ADDR_ASYNC_MODE, 8'h88);
    cap_len = 4'hA;
    k = 0;
    while (tx_ready === 1'b1 && k < 40) begin
      d = 8'($urandom);
      exp_q.push_back(frame(d, 8'h88, n));
      wr_reg(ADDR_DATA, d);
      #1;
      k++;
    end
    `CHK(k >= 16, 1'b1)
    wr_reg(ADDR_DATA, 8'h00);
    wait_q(8000);
    $display("test transmit done");
    sync_case(8'h86);
    sync_case(8'h82);
    sync_case(8'h84);
    wr_reg(ADDR_DATA, 8'h5A);
    repeat (BIT * 12) @(posedge clock);
    $display("test three-wire done");
    wrap_up();
  end
endmodule // dmsp_tb_top
